//--- mbsfh_cfg.svh
// Purpose: constants of the serial slave function handler
// Assumes: included by its bare name
// Notes:   byte positions count from the slave address byte
`ifndef MBSFH_CFG_SVH
`define MBSFH_CFG_SVH
`define MBSFH_CRC_INIT   16'hffff
`define MBSFH_CRC_POLY   16'ha001
`define MBSFH_FN_READ    8'h03
`define MBSFH_FN_LOOP    8'h08
`define MBSFH_FN_WRITE   8'h10
`define MBSFH_EXC_FLAG   8'h80
`define MBSFH_ERR_FUNC   8'h01
`define MBSFH_ERR_ADDR   8'h02
`define MBSFH_ERR_DATA   8'h03
`define MBSFH_BCAST_ADDR 8'h00
`define MBSFH_MAX_QTY    16'h0010
`define MBSFH_BUF_LEN    41
`define MBSFH_FIX_LEN    6'h08
`define MBSFH_MIN_LEN    6'h04
`define MBSFH_WRHDR_LEN  6'h09
`define MBSFH_ECHO_LEN   6'h06
`define MBSFH_EXC_LEN    6'h03
`define MBSFH_RDHDR_LEN  6'h03
`define MBSFH_POS_BCNT   6'h02
`define MBSFH_POS_WDATA  6'h07
`endif

//--- mbsfh_pkg.sv
// Purpose: types shared by the function handler and its ports
// Assumes: nothing
// Notes:   none
package mbsfh_pkg;
  typedef struct packed {
    logic       vld;
    logic       eof;
    logic [7:0] data;
  } mbsfh_rx_t;

  typedef struct packed {
    logic       vld;
    logic [7:0] data;
  } mbsfh_tx_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mbsfh_req_t;

  typedef enum logic [2:0] {
    S_RX  = 3'b000,
    S_CHK = 3'b001,
    S_RD  = 3'b010,
    S_RDW = 3'b011,
    S_RDH = 3'b100,
    S_RDL = 3'b101,
    S_WR  = 3'b110,
    S_TX  = 3'b111
  } mbsfh_state_t;
endpackage

//--- mbsfh_crc16.sv
// Purpose: one byte step of the reflected frame check
// Assumes: combinational, used on both receive and transmit paths
// Notes:   eight shift steps unrolled by the loop
`timescale 1ns/100ps
`include "mbsfh_cfg.svh"
module mbsfh_crc16 (
  // running value and data byte in, next value out
  input  wire logic [15:0] i_crc,
  input  wire logic [7:0]  i_byte,
  output logic      [15:0] o_crc
);
  always_comb begin
    logic [15:0] c;
    c = i_crc ^ {8'h00, i_byte};
    for (int k = 0; k < 8; k++) begin
      c = c[0] ? ((c >> 1) ^ `MBSFH_CRC_POLY) : (c >> 1);
    end
    o_crc = c;
  end
endmodule // mbsfh_crc16

//--- mbsfh_top.sv
// Purpose: slave handler for read, loopback and write-multiple commands
// Assumes: framer delivers bytes and a separate end-of-frame pulse
// Notes:   one frame buffer holds the command and is rewritten in place
`timescale 1ns/100ps
`include "mbsfh_cfg.svh"
module mbsfh_top #(
  parameter logic [16:0] REG_SPACE = 17'h10000
) (
  // clock and reset
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_sys_rst,
  // configuration and save request
  input  wire logic [7:0]           i_slave_addr,
  input  wire logic                 i_enter,
  // receive byte stream
  input  wire mbsfh_pkg::mbsfh_rx_t i_rx,
  // transmit byte stream
  input  wire logic                 i_tx_ready,
  output mbsfh_pkg::mbsfh_tx_t      o_tx,
  // register map access
  input  wire logic [15:0]          i_rd_data,
  output mbsfh_pkg::mbsfh_req_t     o_reg,
  // persistence
  output logic                      o_dirty,
  output logic                      o_save
);
  import mbsfh_pkg::*;

  logic [7:0]   buf_mem [`MBSFH_BUF_LEN];
  mbsfh_state_t state_r,  state_nxt;
  logic [5:0]   len_r,    len_nxt;
  logic         ovf_r,    ovf_nxt;
  logic [15:0]  rcrc_r,   rcrc_nxt;
  logic [15:0]  tcrc_r,   tcrc_nxt;
  logic [5:0]   idx_r,    idx_nxt;
  logic [5:0]   tlen_r,   tlen_nxt;
  logic [15:0]  start_r,  start_nxt;
  logic [4:0]   qty_r,    qty_nxt;
  logic [15:0]  hold_r,   hold_nxt;
  logic         bcast_r,  bcast_nxt;
  logic         exc_r,    exc_nxt;
  logic         dirty_r,  dirty_nxt;
  logic         save_r,   save_nxt;
  mbsfh_tx_t    tx_r,     tx_nxt;
  mbsfh_req_t   reg_r,    reg_nxt;
  logic         buf_we;
  logic [5:0]   buf_wa;
  logic [7:0]   buf_wd;
  logic [7:0]   tx_byte;
  logic [15:0]  rx_crc_out;
  logic [15:0]  tx_crc_out;
  logic [15:0]  c_start;
  logic [15:0]  c_qty;
  logic [16:0]  c_end;
  logic         c_qty_ok;
  logic         c_good;

  assign o_tx    = tx_r;
  assign o_reg   = reg_r;
  assign o_dirty = dirty_r;
  assign o_save  = save_r;

  // bytes leave in order; loopback needs no rewrite, exceptions patch fn
  assign tx_byte = (idx_r == 6'h01 && exc_r) ?
                   (buf_mem[1] | `MBSFH_EXC_FLAG) : buf_mem[idx_r];

  mbsfh_crc16 u_rx_crc (
    .i_crc  (rcrc_r),
    .i_byte (i_rx.data),
    .o_crc  (rx_crc_out)
  );

  mbsfh_crc16 u_tx_crc (
    .i_crc  (tcrc_r),
    .i_byte (tx_byte),
    .o_crc  (tx_crc_out)
  );

  // command header decode, valid while in S_CHK
  assign c_start  = {buf_mem[2], buf_mem[3]};
  assign c_qty    = {buf_mem[4], buf_mem[5]};
  assign c_end    = {1'b0, c_start} + {1'b0, c_qty};
  assign c_qty_ok = (c_qty != 16'h0000) && (c_qty <= `MBSFH_MAX_QTY);
  // check residue over data plus received check is zero when intact
  assign c_good   = !ovf_r && (len_r >= `MBSFH_MIN_LEN) &&
                    (rcrc_r == 16'h0000) &&
                    (buf_mem[0] == i_slave_addr ||
                     buf_mem[0] == `MBSFH_BCAST_ADDR);

  always_comb begin
    state_nxt = state_r;
    len_nxt   = len_r;
    ovf_nxt   = ovf_r;
    rcrc_nxt  = rcrc_r;
    tcrc_nxt  = tcrc_r;
    idx_nxt   = idx_r;
    tlen_nxt  = tlen_r;
    start_nxt = start_r;
    qty_nxt   = qty_r;
    hold_nxt  = hold_r;
    bcast_nxt = bcast_r;
    exc_nxt   = exc_r;
    tx_nxt    = tx_r;
    reg_nxt   = '0;
    buf_we    = 1'b0;
    buf_wa    = 6'h00;
    buf_wd    = 8'h00;
    unique case (state_r)
      S_RX: begin
        if (i_rx.eof) begin
          state_nxt = S_CHK;
        end else if (i_rx.vld) begin
          rcrc_nxt = rx_crc_out;
          if (len_r < 6'(`MBSFH_BUF_LEN)) begin
            buf_we  = 1'b1;
            buf_wa  = len_r;
            buf_wd  = i_rx.data;
            len_nxt = len_r + 6'h01;
          end else begin
            ovf_nxt = 1'b1;
          end
        end
      end
      S_CHK: begin
        len_nxt   = 6'h00;
        ovf_nxt   = 1'b0;
        rcrc_nxt  = `MBSFH_CRC_INIT;
        tcrc_nxt  = `MBSFH_CRC_INIT;
        idx_nxt   = 6'h00;
        exc_nxt   = 1'b0;
        bcast_nxt = (buf_mem[0] == `MBSFH_BCAST_ADDR);
        start_nxt = c_start;
        qty_nxt   = c_qty[4:0];
        state_nxt = S_RX;
        buf_wa    = `MBSFH_POS_BCNT;
        if (c_good) begin
          exc_nxt   = 1'b1;
          tlen_nxt  = `MBSFH_EXC_LEN;
          state_nxt = S_TX;
          buf_we    = 1'b1;
          buf_wd    = `MBSFH_ERR_DATA;
          unique case (buf_mem[1])
            `MBSFH_FN_READ: begin
              if (len_r == `MBSFH_FIX_LEN && c_qty_ok) begin
                if (c_end > REG_SPACE) begin
                  buf_wd = `MBSFH_ERR_ADDR;
                end else begin
                  exc_nxt   = 1'b0;
                  buf_wd    = {c_qty[6:0], 1'b0};
                  state_nxt = S_RD;
                end
              end
            end
            `MBSFH_FN_LOOP: begin
              if (len_r == `MBSFH_FIX_LEN) begin
                exc_nxt   = 1'b0;
                buf_we    = 1'b0;
                tlen_nxt  = `MBSFH_ECHO_LEN;
              end
            end
            `MBSFH_FN_WRITE: begin
              if (c_qty_ok && buf_mem[6] == {c_qty[6:0], 1'b0} &&
                  len_r == `MBSFH_WRHDR_LEN + {c_qty[4:0], 1'b0}) begin
                if (c_end > REG_SPACE) begin
                  buf_wd = `MBSFH_ERR_ADDR;
                end else begin
                  exc_nxt   = 1'b0;
                  buf_we    = 1'b0;
                  state_nxt = S_WR;
                end
              end
            end
            default: buf_wd = `MBSFH_ERR_FUNC;
          endcase
        end
      end
      S_RD: begin
        reg_nxt.rd   = 1'b1;
        reg_nxt.addr = start_r + 16'(idx_r);
        state_nxt    = S_RDW;
      end
      S_RDW: state_nxt = S_RDH;
      S_RDH: begin
        hold_nxt  = i_rd_data;
        buf_we    = 1'b1;
        buf_wa    = `MBSFH_RDHDR_LEN + {idx_r[4:0], 1'b0};
        buf_wd    = i_rd_data[15:8];
        state_nxt = S_RDL;
      end
      S_RDL: begin
        buf_we  = 1'b1;
        buf_wa  = `MBSFH_RDHDR_LEN + {idx_r[4:0], 1'b0} + 6'h01;
        buf_wd  = hold_r[7:0];
        idx_nxt = idx_r + 6'h01;
        state_nxt = S_RD;
        if (idx_r[4:0] + 5'h01 == qty_r) begin
          idx_nxt   = 6'h00;
          tlen_nxt  = `MBSFH_RDHDR_LEN + {qty_r, 1'b0};
          state_nxt = S_TX;
        end
      end
      S_WR: begin
        reg_nxt.wr    = 1'b1;
        reg_nxt.addr  = start_r + 16'(idx_r);
        reg_nxt.wdata = {buf_mem[`MBSFH_POS_WDATA + {idx_r[4:0], 1'b0}],
          buf_mem[`MBSFH_POS_WDATA + {idx_r[4:0], 1'b0} + 6'h01]};
        idx_nxt = idx_r + 6'h01;
        if (idx_r[4:0] + 5'h01 == qty_r) begin
          idx_nxt   = 6'h00;
          tlen_nxt  = `MBSFH_ECHO_LEN;
          state_nxt = S_TX;
        end
      end
      S_TX: begin
        if (bcast_r) begin
          state_nxt = S_RX;
        end else if (!tx_r.vld || i_tx_ready) begin
          idx_nxt = idx_r + 6'h01;
          if (idx_r < tlen_r) begin
            tx_nxt   = '{vld: 1'b1, data: tx_byte};
            tcrc_nxt = tx_crc_out;
          end else if (idx_r == tlen_r) begin
            tx_nxt = '{vld: 1'b1, data: tcrc_r[7:0]};
          end else if (idx_r == tlen_r + 6'h01) begin
            tx_nxt = '{vld: 1'b1, data: tcrc_r[15:8]};
          end else begin
            tx_nxt    = '0;
            idx_nxt   = 6'h00;
            state_nxt = S_RX;
          end
        end
      end
    endcase
  end

  // volatile until save; a write in the save cycle keeps the flag set
  always_comb begin
    dirty_nxt = reg_nxt.wr | (dirty_r & ~i_enter);
    save_nxt  = i_enter & dirty_r;
  end

  always_ff @(posedge i_sys_clk) begin
    if (buf_we) begin
      buf_mem[buf_wa] <= buf_wd;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= S_RX;
      len_r   <= 6'h00;
      ovf_r   <= 1'b0;
      rcrc_r  <= `MBSFH_CRC_INIT;
      tcrc_r  <= `MBSFH_CRC_INIT;
      idx_r   <= 6'h00;
      tlen_r  <= 6'h00;
      start_r <= 16'h0000;
      qty_r   <= 5'h00;
      hold_r  <= 16'h0000;
      bcast_r <= 1'b0;
      exc_r   <= 1'b0;
      dirty_r <= 1'b0;
      save_r  <= 1'b0;
      tx_r    <= '0;
      reg_r   <= '0;
    end else begin
      state_r <= state_nxt;
      len_r   <= len_nxt;
      ovf_r   <= ovf_nxt;
      rcrc_r  <= rcrc_nxt;
      tcrc_r  <= tcrc_nxt;
      idx_r   <= idx_nxt;
      tlen_r  <= tlen_nxt;
      start_r <= start_nxt;
      qty_r   <= qty_nxt;
      hold_r  <= hold_nxt;
      bcast_r <= bcast_nxt;
      exc_r   <= exc_nxt;
      dirty_r <= dirty_nxt;
      save_r  <= save_nxt;
      tx_r    <= tx_nxt;
      reg_r   <= reg_nxt;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_bad_check;
    state_r == S_CHK && rcrc_r != 16'h0000;
  endsequence
  sequence s_write_done;
    state_r == S_WR ##1 state_r == S_TX;
  endsequence

  a_bcast_no_answer: assert property (tx_r.vld |-> !bcast_r)
    else $error("answer sent for broadcast");
  a_bad_check_drop: assert property (s_bad_check |=>
    state_r == S_RX ##1 (!reg_r.rd && !reg_r.wr))
    else $error("bad check not dropped");
  a_read_limit: assert property (reg_r.rd |->
    (qty_r != 5'h00 && qty_r <= 5'h10))
    else $error("read quantity out of range");
  a_write_order: assert property ((reg_r.wr && $past(reg_r.wr)) |->
    reg_r.addr == $past(reg_r.addr) + 16'h0001)
    else $error("write address not ascending");
  a_exc_fn_bit: assert property ((tx_r.vld && idx_r == 6'h02 &&
    exc_r) |-> tx_r.data[7])
    else $error("exception answer lacks flag bit");
  a_save_after_wr: assert property (save_r |-> $past(dirty_r))
    else $error("save without pending write");
  a_write_answer: assert property (s_write_done |->
    tlen_r == 6'h06)
    else $error("write answer length wrong");
  a_read_answer: assert property ((state_r == S_RDL &&
    idx_r[4:0] + 5'h01 == qty_r) |=>
    tlen_r == 6'h03 + {$past(qty_r), 1'b0})
    else $error("read answer length wrong");
endmodule // mbsfh_top

//--- mbsfh_regmap_model.sv
// Purpose: register map standing behind the handler
// Assumes: read data due one cycle after a read pulse, held one more
// Notes:   outside that window the data bus toggles, never stale
`timescale 1ns/100ps
module mbsfh_regmap_model (
  // clock and reset
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_sys_rst,
  // access from the handler
  input  wire mbsfh_pkg::mbsfh_req_t i_reg,
  output logic [15:0]                o_rd_data
);
  import mbsfh_pkg::*;
  logic [15:0] mem [64];
  logic        d1_r;
  logic        d2_r;
  logic        tog_r;
  logic [15:0] a1_r;
  logic [15:0] a2_r;

  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 16'ha000 | 16'(i);
  end

  always @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      d1_r <= 1'b0;
      d2_r <= 1'b0;
      tog_r <= 1'b0;
    end else begin
      d1_r <= i_reg.rd;
      d2_r <= d1_r;
      a1_r <= i_reg.addr;
      a2_r <= a1_r;
      tog_r <= ~tog_r;
      if (i_reg.wr) mem[i_reg.addr[5:0]] <= i_reg.wdata;
    end
  end

  // a late sample must not see the right word by luck
  assign o_rd_data = d1_r ? mem[a1_r[5:0]] :
                     d2_r ? mem[a2_r[5:0]] : {8{tog_r, ~tog_r}};
endmodule // mbsfh_regmap_model

//--- tb_modbus_slave_function_handler.sv
// Purpose: self-checking bench of the function handler
// Assumes: slave address 01, register space shrunk to 64 words
// Notes:   sink stalls every other cycle while a response drains
`timescale 1ns/100ps
module tb_modbus_slave_function_handler;
  import mbsfh_pkg::*;
  typedef logic [7:0] mbsfh_bq_t [$];
  typedef struct {
    logic [87:0] c;
    int          nc;
    logic [87:0] r;
    int          nr;
  } mbsfh_row_t;

  logic        i_sys_clk;
  logic        i_sys_rst;
  logic        i_enter;
  logic        i_tx_ready;
  logic [15:0] i_rd_data;
  mbsfh_rx_t   i_rx;
  mbsfh_tx_t   o_tx;
  mbsfh_req_t  o_reg;
  logic        o_dirty;
  logic        o_save;
  int          n_mismatch;
  int          n_checks;
  int          n_wr;
  mbsfh_bq_t   cq;
  mbsfh_bq_t   rq;
  mbsfh_row_t  rows [10] = '{
    '{88'h01_08_00_00_a5_37, 6, 88'h01_08_00_00_a5_37, 6},
    '{88'h01_08_ff_ff_12_34, 6, 88'h01_08_ff_ff_12_34, 6},
    '{88'h01_10_00_20_00_02_04_12_34_56_78, 11, 88'h01_10_00_20_00_02, 6},
    '{88'h01_03_00_20_00_02, 6, 88'h01_03_04_12_34_56_78, 7},
    '{88'h01_05_00_20_00_01, 6, 88'h01_85_01, 3},
    '{88'h01_03_00_00_00_11, 6, 88'h01_83_03, 3},
    '{88'h01_03_00_00_00_00, 6, 88'h01_83_03, 3},
    '{88'h01_10_00_20_00_02_03_12_34_56_78, 11, 88'h01_90_03, 3},
    '{88'h05_03_00_20_00_01, 6, 88'h0, 0},
    '{88'h01_03_00_3f_00_02, 6, 88'h01_83_02, 3}};

  mbsfh_top #(.REG_SPACE(17'h00040)) uut (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_slave_addr(8'h01), .i_enter(i_enter), .i_rx(i_rx),
    .i_tx_ready(i_tx_ready), .o_tx(o_tx), .i_rd_data(i_rd_data),
    .o_reg(o_reg), .o_dirty(o_dirty), .o_save(o_save));

  mbsfh_regmap_model pm (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_reg(o_reg), .o_rd_data(i_rd_data));

  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  task automatic check(input string nm, input logic [15:0] s, e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [15:0] crc16(input mbsfh_bq_t q);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction

  function automatic mbsfh_bq_t to_q(input logic [87:0] v, input int n);
    mbsfh_bq_t q;
    for (int i = 0; i < n; i++) q.push_back(v[8*(n-1-i) +: 8]);
    return q;
  endfunction

  // send a frame with its check, collect the answer for a fixed span
  task automatic run(input mbsfh_bq_t c, input mbsfh_bq_t r, input bit bad);
    logic [15:0] k;
    mbsfh_bq_t   got;
    k = crc16(c) ^ {15'h0, bad};
    c.push_back(k[7:0]);
    c.push_back(k[15:8]);
    if (r.size() > 0) begin
      k = crc16(r);
      r.push_back(k[7:0]);
      r.push_back(k[15:8]);
    end
    n_wr = 0;
    foreach (c[i]) begin
      i_rx = '{1'b1, 1'b0, c[i]};
      @(negedge i_sys_clk);
    end
    i_rx = '{1'b0, 1'b1, 8'h00};
    @(negedge i_sys_clk);
    i_rx = '0;
    repeat (200) begin
      i_tx_ready = ~i_tx_ready;
      if (o_tx.vld === 1'b1 && i_tx_ready) got.push_back(o_tx.data);
      if (o_reg.wr === 1'b1) n_wr++;
      @(negedge i_sys_clk);
    end
    check("tx length", 16'(got.size()), 16'(r.size()));
    foreach (r[i]) begin
      if (i < got.size()) check("tx byte", {8'h0, got[i]}, {8'h0, r[i]});
    end
  endtask

  initial begin
    #(8 * 20000);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    n_mismatch = 0;
    n_checks = 0;
    i_sys_rst = 1'b1;
    i_enter = 1'b0;
    i_tx_ready = 1'b0;
    i_rx = '0;
    repeat (4) @(negedge i_sys_clk);
    i_sys_rst = 1'b0;
    check("reset outputs",
          16'({o_tx, o_reg.rd, o_reg.wr, o_dirty, o_save}), 16'h0);
    foreach (rows[i]) begin
      run(to_q(rows[i].c, rows[i].nc), to_q(rows[i].r, rows[i].nr), 1'b0);
      if (i == 2) check("write count", 16'(n_wr), 16'd2);
    end
    check("word at start", pm.mem[32], 16'h1234);
    check("word at start+1", pm.mem[33], 16'h5678);
    check("no save yet", {o_dirty, o_save}, 16'h2);
    i_enter = 1'b1;
    @(negedge i_sys_clk);
    i_enter = 1'b0;
    check("save pulse", {15'h0, o_save}, 16'h1);
    @(negedge i_sys_clk);
    check("after save", {o_dirty, o_save}, 16'h0);
    cq = to_q(88'h01_10_00_21_00_01_02_ab_cd, 9);
    rq = {};
    run(cq, rq, 1'b1);
    check("bad check writes", 16'(n_wr), 16'd0);
    check("bad check word", pm.mem[33], 16'h5678);
    cq = to_q(88'h00_10_00_30_00_01_02_ab_cd, 9);
    run(cq, rq, 1'b0);
    check("broadcast writes", 16'(n_wr), 16'd1);
    check("broadcast word", pm.mem[48], 16'habcd);
    cq = to_q(88'h01_03_00_20_00_10, 6);
    rq = to_q(88'h01_03_20, 3);
    for (int i = 32; i < 48; i++) begin
      rq.push_back(pm.mem[i][15:8]);
      rq.push_back(pm.mem[i][7:0]);
    end
    run(cq, rq, 1'b0);
    report_and_stop();
  end
endmodule // tb_modbus_slave_function_handler
